//--- inc/afr_pkg.sv
// Purpose: Shared constants for the accumulator and flag register block
// Assumes: Operand addressing by register type, number and subnumber
// Notes: Widths follow the per-channel precision of each data mode
package afr_pkg;
   localparam logic [3:0] ARF_TYPE_ACC = 4'h2;
   localparam logic [3:0] ARF_TYPE_FLAG = 4'h3;
   localparam logic [3:0] REGNUM_FIRST = 4'h0;
   localparam logic [3:0] REGNUM_SECOND = 4'h1;
   localparam logic [4:0] SUBREG_FLAG_LOW = 5'h00;
   localparam logic [4:0] SUBREG_FLAG_HIGH = 5'h02;
   localparam int FLAG_SUB_W = 16;
   localparam int FLAG_W = 32;
   localparam int FLAG_HIGH_LSB = 16;
   localparam int HALF_W = 8;
   localparam int DW_CHANNELS = 8;
   localparam int DW_BITS = 64;
   localparam int W_CHANNELS = 16;
   localparam int W_BITS = 33;
   localparam int W_SIGN_BIT = 32;
   localparam int F_EXP_BITS = 8;
   localparam int F_MANT_BITS = 54;
   localparam int CH_BITS = 64;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 32'h0000_0000;
   localparam logic [1:0] STALL_CYCLES = 2'h1;

   typedef enum logic [1:0] {
      AFR_MODE_FLOAT = 2'h0,
      AFR_MODE_DWORD = 2'h1,
      AFR_MODE_WORD = 2'h3
   } afr_mode_e;
endpackage : afr_pkg

//--- tb/afr_pipe_model.sv
// Purpose: Pipeline stand-in issuing accumulator accesses
// Assumes: Caller holds mode, channel and read register
// Notes: One go pulse gives a write, then a read next cycle
`timescale 1ns/1ns
module afr_pipe_model (
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic [63:0] i_data,
   output logic o_wr,
   output logic o_rd,
   output logic [63:0] o_data
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_data = 64'h0;
   end
   always @(posedge i_core_clk) begin
      o_wr <= i_go;
      // Read right behind the write, the costly back-to-back case
      o_rd <= o_wr;
      // Idle data toggles so a stale value never looks valid
      o_data <= i_go ? i_data : ~o_data;
   end
endmodule : afr_pipe_model

//--- tb/afr_regfile_sva.sv
// Purpose: Port checks on the accumulator and flag block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every register file instance
`timescale 1ns/1ns
module afr_regfile_sva
   import afr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_acc_wr,
   input wire logic i_acc_wr_explicit,
   input wire logic [3:0] i_acc_wr_regnum,
   input wire logic i_acc_rd,
   input wire logic i_acc_rd_explicit,
   input wire logic [3:0] i_acc_rd_regnum,
   input wire logic [31:0] i_fsrc,
   input wire logic i_fsrc_is_acc,
   input wire logic [3:0] i_flag_regtype,
   input wire logic [4:0] i_flag_subreg,
   input wire logic i_flag_whole,
   input wire logic i_flag_wr,
   input wire logic [63:0] o_acc_rd_data,
   input wire logic o_stall,
   input wire logic [31:0] o_fsrc,
   input wire logic o_flag_reserved
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   property p_stall;
      i_acc_wr && i_acc_wr_explicit ##1 i_acc_rd && i_acc_rd_explicit &&
         i_acc_rd_regnum == $past(i_acc_wr_regnum) |=> o_stall;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall");
   property p_nostall;
      !i_acc_wr ##1 1'b1 |=> !o_stall;
   endproperty
   a_nostall: assert property (p_nostall) else $error("stall");
   property p_pulse;
      o_stall |=> !o_stall;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long stall");
   property p_hold;
      !i_acc_rd |=> $stable(o_acc_rd_data);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_flush;
      !i_fsrc_is_acc && i_fsrc[30:23] == 8'h00 |=>
         o_fsrc == ($past(i_fsrc) & 32'h8000_0000);
   endproperty
   a_flush: assert property (p_flush) else $error("no flush");
   property p_keep;
      i_fsrc_is_acc |=> o_fsrc == $past(i_fsrc);
   endproperty
   a_keep: assert property (p_keep) else $error("acc flushed");
   property p_rsv_type;
      i_flag_wr && i_flag_regtype != ARF_TYPE_FLAG |=> o_flag_reserved;
   endproperty
   a_rsv_type: assert property (p_rsv_type) else $error("type");
   property p_rsv_sub;
      i_flag_wr && !i_flag_whole && i_flag_subreg != SUBREG_FLAG_LOW &&
         i_flag_subreg != SUBREG_FLAG_HIGH |=> o_flag_reserved;
   endproperty
   a_rsv_sub: assert property (p_rsv_sub) else $error("sub");
   c_stall: cover property (o_stall);
   c_flush: cover property (!i_fsrc_is_acc && i_fsrc[30:23] == 8'h00);
   c_rsv: cover property (o_flag_reserved);
endmodule : afr_regfile_sva
bind afr_regfile afr_regfile_sva u_sva (.*);

//--- tb/tb.sv
// Purpose: Self-checking bench for the accumulator and flag block
// Assumes: Pipeline model drives accumulator strobes and data
// Notes: Flags are read back through the explicit read selection
`timescale 1ns/1ns
module tb;
   import afr_pkg::*;
   logic i_core_clk, i_reset_n, i_acc_wr, i_acc_wr_explicit, i_acc_rd;
   logic i_acc_rd_explicit, i_second_half, i_fsrc_is_acc, i_flag_whole;
   logic i_flag_wr, i_cond_wr, o_stall, o_flag_reserved, go;
   logic [3:0] i_acc_wr_regnum, i_acc_wr_chan, i_acc_rd_regnum;
   logic [3:0] i_acc_rd_chan, i_flag_regtype;
   afr_mode_e i_acc_wr_mode, i_acc_rd_mode;
   logic [4:0] i_flag_subreg;
   logic [15:0] i_cond_result, i_emask, o_predicate;
   logic [31:0] i_fsrc, i_flag_wr_data, o_fsrc, o_flag_rd_data;
   logic [63:0] i_acc_wr_data, o_acc_rd_data, wdata;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   afr_regfile dut (.*);
   afr_pipe_model u_pipe (.i_core_clk(i_core_clk), .i_go(go),
      .i_data(wdata), .o_wr(i_acc_wr), .o_rd(i_acc_rd),
      .o_data(i_acc_wr_data));
   initial i_core_clk = 1'b0;
   always #50 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (checked > 0 && miscompares == 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [63:0] got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic acc_op(input afr_mode_e m, input logic [3:0] ch, rr,
         input logic [63:0] d);
      {i_acc_wr_mode, i_acc_rd_mode} = {m, m};
      {i_acc_wr_chan, i_acc_rd_chan, i_acc_rd_regnum} = {ch, ch, rr};
      wdata = d;
      go = 1'b1;
      @(posedge i_core_clk);
      #1 go = 1'b0;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask : acc_op
   task automatic t_acc();
      acc_op(AFR_MODE_WORD, 4'hf, REGNUM_FIRST, 64'h0000_0001_ffff_fffe);
      chk("stall", o_stall, 1'b1);
      chk("word", o_acc_rd_data, 64'hffff_ffff_ffff_fffe);
      // Plain dword value, never a negated unsigned product
      acc_op(AFR_MODE_DWORD, 4'h7, REGNUM_FIRST, 64'h8123_4567_89ab_cdef);
      chk("dword", o_acc_rd_data, 64'h8123_4567_89ab_cdef);
      acc_op(AFR_MODE_FLOAT, 4'h0, REGNUM_FIRST, 64'haaff_ffff_ffff_ffff);
      chk("float", o_acc_rd_data, 64'haa3f_ffff_ffff_ffff);
      // Reading the other accumulator dodges the hazard
      acc_op(AFR_MODE_DWORD, 4'h7, REGNUM_SECOND, 64'h1);
      chk("no stall", o_stall, 1'b0);
   endtask : t_acc
   task automatic fsrc(input logic a, input logic [31:0] v, e);
      {i_fsrc_is_acc, i_fsrc} = {a, v};
      @(posedge i_core_clk);
      #1;
      chk("fsrc", o_fsrc, e);
   endtask : fsrc
   task automatic fwr(input logic c, input logic [3:0] t,
         input logic [4:0] s, input logic wh, input logic [31:0] d);
      {i_cond_wr, i_flag_wr, i_flag_regtype, i_flag_subreg} = {c, !c, t, s};
      {i_flag_whole, i_flag_wr_data, i_cond_result} = {wh, d, d[15:0]};
      @(posedge i_core_clk);
      #1 {i_cond_wr, i_flag_wr} = 2'h0;
   endtask : fwr
   task automatic frd(input logic wh, input logic [4:0] s,
         input logic [31:0] e);
      {i_flag_regtype, i_flag_whole, i_flag_subreg} = {ARF_TYPE_FLAG, wh, s};
      repeat (2) @(posedge i_core_clk);
      #1;
      chk("flags", o_flag_rd_data, e);
   endtask : frd
   task automatic t_flags();
      fwr(1'b0, ARF_TYPE_FLAG, SUBREG_FLAG_LOW, 1'b1, 32'h1234_5678);
      frd(1'b1, SUBREG_FLAG_LOW, 32'h1234_5678);
      frd(1'b0, SUBREG_FLAG_HIGH, 32'h1234);
      i_emask = 16'h00ff;
      fwr(1'b1, ARF_TYPE_FLAG, SUBREG_FLAG_LOW, 1'b0, 32'haaaa);
      frd(1'b0, SUBREG_FLAG_LOW, 32'h56aa);
      chk("pred", o_predicate, 16'h56aa);
      i_second_half = 1'b1;
      repeat (2) @(posedge i_core_clk);
      #1 chk("pred half", o_predicate, 16'h0056);
      i_second_half = 1'b0;
      fwr(1'b0, ARF_TYPE_FLAG, 5'h04, 1'b0, 32'hffff_ffff);
      chk("bad sub", o_flag_reserved, 1'b1);
      fwr(1'b0, ARF_TYPE_ACC, SUBREG_FLAG_LOW, 1'b1, 32'hffff_ffff);
      chk("bad type", o_flag_reserved, 1'b1);
      frd(1'b1, SUBREG_FLAG_LOW, 32'h1234_56aa);
      i_emask = 16'hffff;
      fwr(1'b1, ARF_TYPE_FLAG, SUBREG_FLAG_HIGH, 1'b0, 32'h0f0f);
      frd(1'b1, SUBREG_FLAG_LOW, 32'h0f0f_56aa);
   endtask : t_flags
   initial begin
      {i_reset_n, go, i_second_half, i_fsrc_is_acc, i_flag_whole} = 5'h0;
      {i_flag_wr, i_cond_wr, i_fsrc, i_flag_wr_data, wdata} = '0;
      {i_acc_wr_explicit, i_acc_rd_explicit} = 2'h3;
      {i_acc_wr_regnum, i_acc_rd_regnum, i_acc_wr_chan} = 12'h0;
      {i_acc_rd_chan, i_flag_regtype, i_flag_subreg} = 13'h0;
      {i_cond_result, i_emask} = 32'h0;
      i_acc_wr_mode = AFR_MODE_FLOAT;
      i_acc_rd_mode = AFR_MODE_FLOAT;
      repeat (5) @(posedge i_core_clk);
      #1 i_reset_n = 1'b1;
      t_acc();
      fsrc(1'b0, 32'h8000_0001, 32'h8000_0000);
      fsrc(1'b0, 32'h007f_ffff, 32'h0);
      fsrc(1'b0, 32'h3f80_0000, 32'h3f80_0000);
      fsrc(1'b1, 32'h8000_0001, 32'h8000_0001);
      // Minus zero passes unchanged, sign kept
      fsrc(1'b0, 32'h8000_0000, 32'h8000_0000);
      t_flags();
      print_verdict();
   end
endmodule : tb

//--- verilog/afr_denorm_flush.sv
// Purpose: Replace a denormal single-precision operand by signed zero
// Assumes: IEEE single layout
// Notes: Combinational; bypassed for accumulator sources
`timescale 1ns/1ns
module afr_denorm_flush (
   input wire logic [31:0] i_value,
   input wire logic i_bypass,
   output logic [31:0] o_value
);
   wire is_denorm = (i_value[30:23] == 8'h00) && (i_value[22:0] != 23'h0);
   // Sign kept so that minus zero survives
   assign o_value = (is_denorm && !i_bypass) ?
                    {i_value[31], 31'h0000_0000} : i_value; // see RULE9
endmodule : afr_denorm_flush

//--- verilog/afr_flag_merge.sv
// Purpose: Per-channel masked merge of condition results into a flag half
// Assumes: One flag bit per channel
// Notes: Generate loop gives each bit its own write enable
`timescale 1ns/1ns
module afr_flag_merge #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] i_old,
   input wire logic [WIDTH-1:0] i_cond,
   input wire logic [WIDTH-1:0] i_enable,
   output logic [WIDTH-1:0] o_new
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         assign o_new[g] = i_enable[g] ? i_cond[g] : i_old[g]; // see RULE17
      end
   endgenerate
endmodule : afr_flag_merge

//--- verilog/afr_regfile.sv
// Purpose: Accumulator storage and condition flag register of a SIMD unit
// Assumes: One operand write and one operand read port per cycle
// Notes: Storage has no architectural reset; flags cleared for determinism
// Rules from the document, for this block and for software
// RULE1 - May stall reader of just-written accumulator
// RULE2 - Software alternates accumulators to avoid stall
// RULE3 - Dword mode: 8 channels of 64 bits
// RULE4 - Software avoids negated unsigned dword multiplies
// RULE5 - Word mode: 16 channels of 33 bits
// RULE6 - Word values two's complement, sign bit 32
// RULE7 - Word overflow wraps modulo; flags may err
// RULE8 - Float mode: 8-bit exponent, 54-bit mantissa
// RULE9 - Float sources denormals flushed to signed zero
// RULE10 - Accumulator float sources are never flushed
// RULE11 - Software flushes via multiply or minus zero add
// RULE12 - Flags: two 16-bit subregisters, bit per channel
// RULE13 - Flag type 0011b, subregisters 00000, 00010
// RULE14 - Second half uses upper eight flag bits
// RULE15 - Predicate and condition share one subregister
// RULE16 - Flag bits hold latest condition outcome
// RULE17 - Condition writes only enabled channel bits
// RULE18 - Flags usable whole or per subregister explicitly
// RULE19 - High subregister bits 31:16, low 15:0
// RULE20 - Two accumulators, type 0010b, dword or word
// RULE21 - Implicit first; second half uses second
`timescale 1ns/1ns
module afr_regfile
   import afr_pkg::*;
#(
   parameter int CHANNELS = 16
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Accumulator write port
   input wire logic i_acc_wr,
   input wire logic i_acc_wr_explicit,
   input wire logic [3:0] i_acc_wr_regnum,
   input wire afr_pkg::afr_mode_e i_acc_wr_mode,
   input wire logic [3:0] i_acc_wr_chan,
   input wire logic [63:0] i_acc_wr_data,
   // Accumulator read port
   input wire logic i_acc_rd,
   input wire logic i_acc_rd_explicit,
   input wire logic [3:0] i_acc_rd_regnum,
   input wire afr_pkg::afr_mode_e i_acc_rd_mode,
   input wire logic [3:0] i_acc_rd_chan,
   input wire logic i_second_half,
   // Float source operand path
   input wire logic [31:0] i_fsrc,
   input wire logic i_fsrc_is_acc,
   // Flag access
   input wire logic [3:0] i_flag_regtype,
   input wire logic [4:0] i_flag_subreg,
   input wire logic i_flag_whole,
   input wire logic i_flag_wr,
   input wire logic [31:0] i_flag_wr_data,
   input wire logic i_cond_wr,
   input wire logic [15:0] i_cond_result,
   input wire logic [15:0] i_emask,
   output logic [63:0] o_acc_rd_data,
   output logic o_stall,
   output logic [31:0] o_fsrc,
   output logic [31:0] o_flag_rd_data,
   output logic [15:0] o_predicate,
   output logic o_flag_reserved
);
   import afr_pkg::*;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic acc_sel(input logic expl,
                                    input logic [3:0] regnum,
                                    input logic sec);
      // Explicit number wins; implicit follows compression half
      acc_sel = expl ? (regnum == REGNUM_SECOND) : sec; // see RULE21
   endfunction : acc_sel

   // Linear channel index: word mode packs 16 lanes, others 8
   function automatic logic [4:0] lane(input logic acc,
                                       input afr_mode_e mode,
                                       input logic [3:0] chan);
      if (mode == AFR_MODE_WORD) begin
         lane = {acc, chan};
      end else begin
         lane = {acc, 1'b0, chan[2:0]};
      end
   endfunction : lane

   wire wr_acc = acc_sel(i_acc_wr_explicit, i_acc_wr_regnum, i_second_half);
   wire rd_acc = acc_sel(i_acc_rd_explicit, i_acc_rd_regnum, i_second_half);
   wire [4:0] wr_lane = lane(wr_acc, i_acc_wr_mode, i_acc_wr_chan);
   wire [4:0] rd_lane = lane(rd_acc, i_acc_rd_mode, i_acc_rd_chan);

   wire flag_type_ok = (i_flag_regtype == ARF_TYPE_FLAG); // see RULE13
   wire sub_low = (i_flag_subreg == SUBREG_FLAG_LOW);
   wire sub_high = (i_flag_subreg == SUBREG_FLAG_HIGH);
   wire flag_ok = flag_type_ok && (i_flag_whole || sub_low || sub_high);

   // ------------------------------------------------------------
   // Accumulator storage
   // ------------------------------------------------------------
   // 2 accumulators x 16 lanes x 64 bits covers every mode
   logic [CH_BITS-1:0] acc_mem [0:31]; // see RULE20

   // Word mode keeps 33 bits sign-extended from bit 32; carry lost
   wire [W_BITS-1:0] word_val = i_acc_wr_data[W_BITS-1:0]; // see RULE5
   wire [CH_BITS-1:0] word_ext = {{(CH_BITS-W_BITS){word_val[W_SIGN_BIT]}},
                                  word_val}; // see RULE6 RULE7
   // Float: exponent in top byte, 54-bit mantissa below
   wire [CH_BITS-1:0] float_val = {i_acc_wr_data[63:56], 2'b00,
                                   i_acc_wr_data[F_MANT_BITS-1:0]}; // see RULE8
   wire [CH_BITS-1:0] store_val =
      (i_acc_wr_mode == AFR_MODE_WORD) ? word_ext :
      (i_acc_wr_mode == AFR_MODE_FLOAT) ? float_val :
      i_acc_wr_data; // see RULE3

   always_ff @(posedge i_core_clk) begin
      // Compare one bit wider so a count of 16 does not wrap to zero
      if (i_acc_wr && ({1'b0, i_acc_wr_chan} < 5'(CHANNELS))) begin
         acc_mem[wr_lane] <= store_val;
      end
   end

   // ------------------------------------------------------------
   // Back-to-back hazard
   // ------------------------------------------------------------
   logic last_wr_valid;
   logic last_wr_acc;
   logic [1:0] stall_cnt;
   wire hazard = i_acc_rd && last_wr_valid && (last_wr_acc == rd_acc);
   wire [1:0] next_stall_cnt = hazard ? STALL_CYCLES :
      (stall_cnt != 2'h0) ? stall_cnt - 2'h1 : 2'h0;

   // Stalling is cheaper than a forwarding path around the array
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         last_wr_valid <= 1'b0;
         last_wr_acc <= 1'b0;
         stall_cnt <= 2'h0;
         o_stall <= 1'b0;
      end else begin
         last_wr_valid <= i_acc_wr && !o_stall;
         last_wr_acc <= wr_acc;
         stall_cnt <= next_stall_cnt;
         o_stall <= hazard && (stall_cnt == 2'h0); // see RULE1
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_acc_rd_data <= 64'h0;
      end else if (i_acc_rd) begin
         o_acc_rd_data <= acc_mem[rd_lane];
      end
   end

   // ------------------------------------------------------------
   // Float source path
   // ------------------------------------------------------------
   wire [31:0] flushed;
   afr_denorm_flush u_flush (
      .i_value(i_fsrc),
      .i_bypass(i_fsrc_is_acc), // see RULE10
      .o_value(flushed)
   );

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_fsrc <= 32'h0;
      end else begin
         o_fsrc <= flushed; // see RULE9
      end
   end

   // ------------------------------------------------------------
   // Flag register
   // ------------------------------------------------------------
   logic [FLAG_W-1:0] condition_flags; // see RULE12 RULE19
   wire [FLAG_SUB_W-1:0] flag_sub_low = condition_flags[FLAG_SUB_W-1:0];
   wire [FLAG_SUB_W-1:0] flag_sub_high =
      condition_flags[FLAG_W-1:FLAG_HIGH_LSB];
   // Same subregister serves predication and condition result
   wire [FLAG_SUB_W-1:0] sel_sub = sub_high ? flag_sub_high
                                            : flag_sub_low; // see RULE15
   // Second half: lower channels map onto upper eight flag bits
   wire [FLAG_SUB_W-1:0] cond_pos = i_second_half ?
      {i_cond_result[HALF_W-1:0], 8'h00} : i_cond_result; // see RULE14
   wire [FLAG_SUB_W-1:0] en_pos = i_second_half ?
      {i_emask[HALF_W-1:0], 8'h00} : i_emask;
   wire [FLAG_SUB_W-1:0] pred_pos = i_second_half ?
      {8'h00, sel_sub[FLAG_SUB_W-1:HALF_W]} : sel_sub; // see RULE14
   wire [FLAG_SUB_W-1:0] merged;

   afr_flag_merge #(
      .WIDTH(FLAG_SUB_W)
   ) u_merge (
      .i_old(sel_sub),
      .i_cond(cond_pos),
      .i_enable(en_pos),
      .o_new(merged)
   );

   wire cond_go = i_cond_wr && flag_type_ok && (sub_low || sub_high);
   wire expl_go = i_flag_wr && flag_ok;
   // Explicit write: whole dword or one subregister
   wire [FLAG_W-1:0] expl_val = i_flag_whole ? i_flag_wr_data :
      sub_high ? {i_flag_wr_data[FLAG_SUB_W-1:0], flag_sub_low} :
      {flag_sub_high, i_flag_wr_data[FLAG_SUB_W-1:0]}; // see RULE18
   wire [FLAG_W-1:0] cond_val = sub_high ? {merged, flag_sub_low}
                                         : {flag_sub_high, merged};
   wire [FLAG_W-1:0] next_flags = cond_go ? cond_val :
      expl_go ? expl_val : condition_flags; // see RULE16

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         condition_flags <= FLAG_RESET;
      end else begin
         condition_flags <= next_flags;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_flag_rd_data <= 32'h0;
         o_predicate <= 16'h0;
         o_flag_reserved <= 1'b0;
      end else begin
         o_flag_rd_data <= i_flag_whole ? condition_flags :
                           {16'h0, sel_sub}; // see RULE18
         o_predicate <= pred_pos;
         o_flag_reserved <= (i_flag_wr || i_cond_wr) && !flag_ok;
      end
   end
endmodule : afr_regfile
